// file: flash_status_protect_config_tb.sv
// Self-checking bench of the flash status and protection logic
`default_nettype none
module flash_status_protect_config_tb import fsp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic writeProtectPin = 1'b1;
  logic sharedPin = 1'b1;
  logic opReq = 1'b0;
  logic [21:0] opFirst = 22'h0;
  logic [21:0] opLast = 22'h0;
  logic blockLockHit = 1'b0;
  logic opDone = 1'b0;
  wire logic linkClk, linkRstn, linkStrobe;
  wire logic [7:0] linkOpcode;
  wire logic [23:0] linkData, statusWord;
  wire logic opGrant, opDeny, fourWireMode, dataLine2En, dataLine3En;
  wire logic pauseActive, resetRequest, lockInit;
  wire logic [6:0] drivePercent;
  int nMismatch = 0;
  int checksDone = 0;
  int cyc = 0;
  integer seed = 32'hf9514c1a;
  integer a, b;
  logic [21:0] f, l;
  logic [23:0] expS = 24'h0;
  logic fw = 1'b0;
  logic [23:0] pinCfg [3] = '{24'h0, 24'h800000, 24'h800200};
  logic [32:0] seqT [] = '{33'h001000004, 33'h006000000, 33'h001000084, 33'h006000000,
    33'h001000088, 33'h104000000, 33'h10100008c, 33'h106000000, 33'h101000110,
    33'h106000000, 33'h101000000, 33'h100000000, 33'h106000000, 33'h101000180,
    33'h106000000, 33'h101000000, 33'h100000000, 33'h106000000, 33'h101000800,
    33'h106000000, 33'h101000000, 33'h106000000, 33'h101002000, 33'h175000000,
    33'h17a000000, 33'h175000000, 33'h100000000, 33'h138000000, 33'h106000000,
    33'h101000200, 33'h138000000, 33'h106000000, 33'h101000000, 33'h1ff000000};
  fsp_host_model fsp_host_model_i (.linkClk(linkClk), .linkRstn(linkRstn),
    .linkStrobe(linkStrobe), .linkOpcode(linkOpcode), .linkData(linkData));
  fsp_status_protect fsp_status_protect_i (.clk(clk), .rstn(rstn), .linkClk(linkClk),
    .linkRstn(linkRstn), .linkStrobe(linkStrobe), .linkOpcode(linkOpcode),
    .linkData(linkData), .writeProtectPin(writeProtectPin), .sharedPin(sharedPin),
    .opReq(opReq), .opFirst(opFirst), .opLast(opLast), .blockLockHit(blockLockHit),
    .opDone(opDone), .statusWord(statusWord), .opGrant(opGrant), .opDeny(opDeny),
    .fourWireMode(fourWireMode), .dataLine2En(dataLine2En), .dataLine3En(dataLine3En),
    .pauseActive(pauseActive), .resetRequest(resetRequest), .lockInit(lockInit),
    .drivePercent(drivePercent));
  always #25 clk = ~clk;
  task automatic report_and_stop();
    if (nMismatch == 0 && checksDone > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      nMismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] want);
    checksDone++;
    if (seen !== want) begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  function automatic logic [23:0] wr(input logic [23:0] s, input logic [23:0] d);
    logic [23:0] n;
    n = (d & 24'hb47bfc) | (s & 24'h00b800);
    n[9] = n[9] | fw;
    return (s[1] && !s[8] && !(s[7] && !writeProtectPin && !s[9])) ? n : s;
  endfunction : wr
  function automatic logic hit(input logic [23:0] s, input logic [21:0] f, input logic [21:0] l);
    logic [22:0] sz;
    logic [21:0] lo, hi;
    int sh;
    sh = s[6] ? (s[4] ? 3 : int'(s[3:2]) - 1) : int'(s[4:2]) - 1;
    sz = (s[6] ? FSP_SECTOR_BYTES : FSP_BLOCK_BYTES) << sh;
    if (s[4:2] == 3'h0) sz = 23'h0;
    if (s[4:2] == 3'h7) sz = FSP_ARRAY_BYTES;
    lo = s[5] ? 22'h0 : 22'(FSP_ARRAY_BYTES - sz);
    hi = s[5] ? 22'(sz - 23'h1) : FSP_TOP_ADDR;
    if (s[14]) return !(sz != 23'h0 && f >= lo && l <= hi);
    return sz != 23'h0 && f <= hi && l >= lo;
  endfunction : hit
  task automatic cmd(input logic [7:0] op, input logic [23:0] d);
    fsp_host_model_i.send(op, d);
    case (op)
      FSP_OP_WREN: expS[1] = 1'b1;
      FSP_OP_WRDI: expS[1] = 1'b0;
      FSP_OP_WRSR: expS = wr(expS, d);
      FSP_OP_SUSPEND: expS[15] = 1'b1;
      FSP_OP_RESUME: expS[15] = 1'b0;
      FSP_OP_QPI_ENTER: fw = fw | expS[9];
      FSP_OP_QPI_EXIT: fw = 1'b0;
      default: ;
    endcase
    repeat (8) @(negedge clk);
    chk("statusWord", statusWord & 24'hb4fbfe, expS);
    chk("fourWireMode", fourWireMode, fw);
  endtask : cmd
  task automatic op(input logic [21:0] f, input logic [21:0] l, input logic lk);
    logic g;
    g = expS[1] && (expS[18] ? !lk : !hit(expS, f, l));
    opReq = 1'b1;
    opFirst = f;
    opLast = l;
    blockLockHit = lk;
    @(negedge clk);
    opReq = 1'b0;
    opFirst = ~f;
    chk("opGrant", opGrant, g);
    chk("opDeny", opDeny, !g);
    @(negedge clk);
  endtask : op
  task automatic pwr();
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    chk("lockInit", lockInit, 1'b1);
    chk("drivePercent", drivePercent, FSP_DRV_FULL);
    rstn = 1'b1;
    expS = 24'h0;
    fw = 1'b0;
    repeat (4) @(negedge clk);
    chk("statusWord", statusWord & 24'hb4fbfe, 24'h0);
    chk("lockInit", lockInit, 1'b0);
  endtask : pwr
  initial begin
    for (int k = 0; k < 3; k++) begin
      pwr();
      cmd(FSP_OP_WREN, 24'h0);
      cmd(FSP_OP_WRSR, pinCfg[k] | (24'(k) << FSP_B_DRV));
      chk("drivePercent", drivePercent, k == 0 ? FSP_DRV_FULL : k == 1 ? FSP_DRV_75 : FSP_DRV_50);
      sharedPin = 1'b0;
      repeat (4) @(negedge clk);
      chk("pauseActive", pauseActive, k == 0);
      chk("resetRequest", resetRequest, k == 1);
      chk("lockInit", lockInit, k == 1);
      chk("dataLine2En", dataLine2En, k == 2);
      chk("dataLine3En", dataLine3En, k == 2);
      sharedPin = 1'b1;
    end
    pwr();
    cmd(FSP_OP_WREN, 24'h0);
    cmd(FSP_OP_WRSR, 24'h300000);
    chk("drivePercent", drivePercent, FSP_DRV_25);
    foreach (seqT[i]) begin
      writeProtectPin = seqT[i][32];
      repeat (4) @(negedge clk);
      if (seqT[i][31:24] == 8'h00) pwr();
      else cmd(seqT[i][31:24], seqT[i][23:0]);
    end
    cmd(FSP_OP_WREN, 24'h0);
    cmd(FSP_OP_WRSR, 24'h004004);
    cmd(FSP_OP_WREN, 24'h0);
    op(22'h3f0000, 22'h3fffff, 1'b0);
    op(22'h3effff, 22'h3f0000, 1'b0);
    cmd(FSP_OP_WRSR, 24'h000064);
    cmd(FSP_OP_WREN, 24'h0);
    op(22'h001000, 22'h001000, 1'b0);
    op(22'h000fff, 22'h001000, 1'b0);
    for (int i = 0; i < 40; i++) begin
      a = $random(seed);
      cmd(FSP_OP_WREN, 24'h0);
      cmd(FSP_OP_WRSR, 24'(a) & 24'hfffe7f);
      cmd(FSP_OP_WREN, 24'h0);
      for (int j = 0; j < 4; j++) begin
        b = $random(seed);
        f = b[30] ? b[21:0] : {{5{b[31]}}, b[16:0]};
        l = f + 22'(b[28:20]);
        if (l < f) l = FSP_TOP_ADDR;
        op(f, l, b[29]);
      end
      opDone = 1'b1;
      @(negedge clk);
      opDone = 1'b0;
      expS[1] = 1'b0;
      repeat (3) @(negedge clk);
      chk("statusWord", statusWord & 24'hb4fbfe, expS);
      op(22'h0, 22'h0, 1'b0);
    end
    report_and_stop();
  end
endmodule : flash_status_protect_config_tb
`default_nettype wire

// file: fsp_host_model.sv
// Serial host model that hands decoded instructions to the link side
`default_nettype none
module fsp_host_model
  import fsp_pkg::*;
(
  output logic linkClk,
  output logic linkRstn,
  output logic linkStrobe,
  output logic [7:0] linkOpcode,
  output logic [FSP_STAT_W-1:0] linkData
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run = 1'b1;
  initial begin
    linkClk = 1'b0;
    linkRstn = 1'b0;
    linkStrobe = 1'b0;
    linkOpcode = 8'h00;
    linkData = 24'h0;
    repeat (3) @(posedge linkClk);
    linkRstn <= 1'b1;
    @(posedge linkClk);
    run = 1'b0;
  end
  // Clock stands still between instructions
  always #3 linkClk = run & ~linkClk;
  task automatic send(input logic [7:0] op, input logic [23:0] d);
    run = 1'b1;
    repeat (2) @(posedge linkClk);
    linkOpcode <= op;
    linkData <= d;
    linkStrobe <= 1'b1;
    @(posedge linkClk);
    linkStrobe <= 1'b0;
    // Released lines no longer show the last value
    linkOpcode <= ~op;
    linkData <= ~d;
    repeat (2) @(posedge linkClk);
    run = 1'b0;
  endtask : send
endmodule : fsp_host_model
`default_nettype wire

// file: fsp_pkg.sv
// Constants shared by the flash status and protection logic
`default_nettype none
package fsp_pkg;
  localparam int FSP_ADDR_W = 22;
  localparam int FSP_STAT_W = 24;
  localparam logic [22:0] FSP_ARRAY_BYTES = 23'h400000;
  localparam logic [22:0] FSP_BLOCK_BYTES = 23'h010000;
  localparam logic [22:0] FSP_SECTOR_BYTES = 23'h001000;
  localparam logic [21:0] FSP_TOP_ADDR = 22'h3fffff;
  // Instruction codes
  localparam logic [7:0] FSP_OP_WREN = 8'h06;
  localparam logic [7:0] FSP_OP_WRDI = 8'h04;
  localparam logic [7:0] FSP_OP_WRSR = 8'h01;
  localparam logic [7:0] FSP_OP_SUSPEND = 8'h75;
  localparam logic [7:0] FSP_OP_RESUME = 8'h7a;
  localparam logic [7:0] FSP_OP_QPI_ENTER = 8'h38;
  localparam logic [7:0] FSP_OP_QPI_EXIT = 8'hff;
  // Status bit positions
  localparam int FSP_B_WEL = 1;
  localparam int FSP_B_BP = 2;
  localparam int FSP_B_TB = 5;
  localparam int FSP_B_SEC = 6;
  localparam int FSP_B_SRP0 = 7;
  localparam int FSP_B_SRP1 = 8;
  localparam int FSP_B_QE = 9;
  localparam int FSP_B_LB = 11;
  localparam int FSP_B_CMP = 14;
  localparam int FSP_B_SUS = 15;
  localparam int FSP_B_WPS = 18;
  localparam int FSP_B_DRV = 20;
  localparam int FSP_B_HRST = 23;
  // Reset values
  localparam logic [2:0] FSP_RST_BP = 3'h0;
  localparam logic [1:0] FSP_RST_SRP = 2'h0;
  localparam logic [2:0] FSP_RST_LB = 3'h0;
  localparam logic [1:0] FSP_RST_DRV = 2'h0;
  // Status protect modes
  localparam logic [1:0] FSP_SRP_SOFT = 2'h0;
  localparam logic [1:0] FSP_SRP_HARD = 2'h1;
  // Drive strength in percent
  localparam logic [6:0] FSP_DRV_FULL = 7'h64;
  localparam logic [6:0] FSP_DRV_75 = 7'h4b;
  localparam logic [6:0] FSP_DRV_50 = 7'h32;
  localparam logic [6:0] FSP_DRV_25 = 7'h19;
endpackage : fsp_pkg
`default_nettype wire

// file: fsp_range_check.sv
// Combinational overlap test of a target range against the protected region
`default_nettype none
module fsp_range_check
  import fsp_pkg::*;
(
  input wire logic [2:0] blockProtect,
  input wire logic bottomSelect,
  input wire logic sectorGran,
  input wire logic complementProt,
  input wire logic [FSP_ADDR_W-1:0] firstAddr,
  input wire logic [FSP_ADDR_W-1:0] lastAddr,
  output logic hitsProtected
);
  wire logic regionNone = (blockProtect == 3'h0);
  wire logic regionAll = (blockProtect == 3'h7);
  // Sector codes 100 to 110 all mean 32KB; 111 is the whole array
  wire logic [2:0] shiftAmt = (sectorGran && blockProtect[2]) ? 3'h3 : blockProtect - 3'h1;
  wire logic [22:0] unitBytes = sectorGran ? FSP_SECTOR_BYTES : FSP_BLOCK_BYTES;
  wire logic [22:0] regionBytes = unitBytes << shiftAmt;
  wire logic [22:0] topLow = FSP_ARRAY_BYTES - regionBytes;
  wire logic [22:0] botHigh = regionBytes - 23'h000001;
  wire logic [FSP_ADDR_W-1:0] regionLo = bottomSelect ? '0 : topLow[FSP_ADDR_W-1:0];
  wire logic [FSP_ADDR_W-1:0] regionHi = bottomSelect ? botHigh[FSP_ADDR_W-1:0] : FSP_TOP_ADDR;
  wire logic touchesRegion = (firstAddr <= regionHi) && (lastAddr >= regionLo);
  wire logic leavesRegion = (firstAddr < regionLo) || (lastAddr > regionHi);
  wire logic plainHit = !regionNone && (regionAll || touchesRegion);
  wire logic invertHit = regionNone || (!regionAll && leavesRegion);
  assign hitsProtected = complementProt ? invertHit : plainHit;
endmodule : fsp_range_check
`default_nettype wire

// file: fsp_status_protect.sv
// Status and configuration registers with array protection of a serial flash
`default_nettype none
module fsp_status_protect
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic linkClk,
  input wire logic linkRstn,
  input wire logic linkStrobe,
  input wire logic [7:0] linkOpcode,
  input wire logic [FSP_STAT_W-1:0] linkData,
  input wire logic writeProtectPin,
  input wire logic sharedPin,
  input wire logic opReq,
  input wire logic [FSP_ADDR_W-1:0] opFirst,
  input wire logic [FSP_ADDR_W-1:0] opLast,
  input wire logic blockLockHit,
  input wire logic opDone,
  output logic [FSP_STAT_W-1:0] statusWord,
  output logic opGrant,
  output logic opDeny,
  output logic fourWireMode,
  output logic dataLine2En,
  output logic dataLine3En,
  output logic pauseActive,
  output logic resetRequest,
  output logic lockInit,
  output logic [6:0] drivePercent
);
  // Link side: hold the decoded instruction and flag it by a toggle
  logic linkTog_r;
  logic [7:0] linkOp_r;
  logic [FSP_STAT_W-1:0] linkWord_r;

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      linkTog_r <= 1'b0;
      linkOp_r <= 8'h00;
      linkWord_r <= '0;
    end else if (linkStrobe) begin
      linkTog_r <= ~linkTog_r;
      linkOp_r <= linkOpcode;
      linkWord_r <= linkData;
    end
  end

  // Crossing and pin synchronisers
  logic togMeta_r;
  logic togSync_r;
  logic togSeen_r;
  logic wpMeta_r;
  logic wpSync_r;
  logic pinMeta_r;
  logic pinSync_r;
  logic cmdArm_r;

  // Toggle chain runs through reset, so a toggle left from before a power cycle is absorbed
  always_ff @(posedge clk) begin
    togMeta_r <= linkTog_r;
    togSync_r <= togMeta_r;
    togSeen_r <= togSync_r;
  end

  // Commands count only from the second edge after reset release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmdArm_r <= 1'b0;
    end else begin
      cmdArm_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wpMeta_r <= 1'b1;
      wpSync_r <= 1'b1;
      pinMeta_r <= 1'b1;
      pinSync_r <= 1'b1;
    end else begin
      wpMeta_r <= writeProtectPin;
      wpSync_r <= wpMeta_r;
      pinMeta_r <= sharedPin;
      pinSync_r <= pinMeta_r;
    end
  end

  // Held words stay stable until the next toggle, so they are read directly
  wire logic cmdNew = cmdArm_r && (togSync_r ^ togSeen_r);
  wire logic [7:0] cmdOp = linkOp_r;
  wire logic [FSP_STAT_W-1:0] cmdWord = linkWord_r;
  wire logic isWren = cmdNew && (cmdOp == FSP_OP_WREN);
  wire logic isWrdi = cmdNew && (cmdOp == FSP_OP_WRDI);
  wire logic isWrsr = cmdNew && (cmdOp == FSP_OP_WRSR);
  wire logic isSusp = cmdNew && (cmdOp == FSP_OP_SUSPEND);
  wire logic isResume = cmdNew && (cmdOp == FSP_OP_RESUME);
  wire logic isQpiIn = cmdNew && (cmdOp == FSP_OP_QPI_ENTER);
  wire logic isQpiOut = cmdNew && (cmdOp == FSP_OP_QPI_EXIT);

  // Status and configuration state
  logic wel_r;
  logic [2:0] bp_r;
  logic tb_r;
  logic sec_r;
  logic [1:0] srp_r;
  logic qe_r;
  logic [2:0] lb_r;
  logic cmp_r;
  logic sus_r;
  logic wps_r;
  logic [1:0] drv_r;
  logic hrst_r;
  logic qpi_r;

  // With quad enable set the protect pin is a data line and has no say
  wire logic wpEffHigh = qe_r || wpSync_r;
  wire logic modeAllows = (srp_r == FSP_SRP_SOFT) ||
    ((srp_r == FSP_SRP_HARD) && wpEffHigh);
  // Modes 10 and 11 never allow a write
  wire logic acceptWrite = isWrsr && wel_r && modeAllows;
  wire logic [2:0] lb_nxt = lb_r | cmdWord[FSP_B_LB +: 3];
  wire logic qe_nxt = cmdWord[FSP_B_QE] || (qpi_r && qe_r);
  // Other instructions leave the latch as it is
  wire logic wel_nxt = isWren || (wel_r && !(isWrdi || acceptWrite || opDone));

  // Power cycle returns lock-down mode to software protection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bp_r <= FSP_RST_BP;
      tb_r <= 1'b0;
      sec_r <= 1'b0;
      srp_r <= FSP_RST_SRP;
      qe_r <= 1'b0;
      lb_r <= FSP_RST_LB;
      cmp_r <= 1'b0;
      wps_r <= 1'b0;
      drv_r <= FSP_RST_DRV;
      hrst_r <= 1'b0;
    end else if (acceptWrite) begin
      // Reserved bits of the word are simply not stored
      bp_r <= cmdWord[FSP_B_BP +: 3];
      tb_r <= cmdWord[FSP_B_TB];
      sec_r <= cmdWord[FSP_B_SEC];
      srp_r <= {cmdWord[FSP_B_SRP1], cmdWord[FSP_B_SRP0]};
      qe_r <= qe_nxt;
      lb_r <= lb_nxt;
      cmp_r <= cmdWord[FSP_B_CMP];
      wps_r <= cmdWord[FSP_B_WPS];
      drv_r <= cmdWord[FSP_B_DRV +: 2];
      hrst_r <= cmdWord[FSP_B_HRST];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wel_r <= 1'b0;
      sus_r <= 1'b0;
      qpi_r <= 1'b0;
    end else begin
      wel_r <= wel_nxt;
      if (isSusp) begin
        sus_r <= 1'b1;
      end else if (isResume) begin
        sus_r <= 1'b0;
      end
      if (isQpiIn && qe_r) begin
        qpi_r <= 1'b1;
      end else if (isQpiOut) begin
        qpi_r <= 1'b0;
      end
    end
  end

  // Protection decision for program and erase
  logic rangeHit;

  fsp_range_check u_range (
    .blockProtect(bp_r),
    .bottomSelect(tb_r),
    .sectorGran(sec_r),
    .complementProt(cmp_r),
    .firstAddr(opFirst),
    .lastAddr(opLast),
    .hitsProtected(rangeHit)
  );

  wire logic isProtected = wps_r ? blockLockHit : rangeHit;
  wire logic grantNxt = opReq && wel_r && !isProtected;
  wire logic denyNxt = opReq && !grantNxt;

  // Shared pin functions only while quad enable is clear
  wire logic pauseNxt = !qe_r && !hrst_r && !pinSync_r;
  wire logic resetNxt = !qe_r && hrst_r && !pinSync_r;
  wire logic [6:0] driveNxt = (drv_r == 2'h0) ? FSP_DRV_FULL :
    (drv_r == 2'h1) ? FSP_DRV_75 :
    (drv_r == 2'h2) ? FSP_DRV_50 : FSP_DRV_25;

  wire logic [FSP_STAT_W-1:0] statusNxt = {
    hrst_r, 1'b0, drv_r, 1'b0, wps_r, 2'h0,
    sus_r, cmp_r, lb_r, 1'b0, qe_r, srp_r[1],
    srp_r[0], sec_r, tb_r, bp_r, wel_r, 1'b0
  };

  always_ff @(posedge clk) begin
    if (!rstn) begin
      statusWord <= '0;
      opGrant <= 1'b0;
      opDeny <= 1'b0;
      fourWireMode <= 1'b0;
      dataLine2En <= 1'b0;
      dataLine3En <= 1'b0;
      pauseActive <= 1'b0;
      resetRequest <= 1'b0;
      lockInit <= 1'b1;
      drivePercent <= FSP_DRV_FULL;
    end else begin
      statusWord <= statusNxt;
      opGrant <= grantNxt;
      opDeny <= denyNxt;
      fourWireMode <= qpi_r;
      dataLine2En <= qe_r;
      dataLine3En <= qe_r;
      pauseActive <= pauseNxt;
      resetRequest <= resetNxt;
      lockInit <= resetNxt;
      drivePercent <= driveNxt;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence wrsrTaken;
    isWrsr && wel_r && (srp_r == FSP_SRP_SOFT);
  endsequence

  sequence wrsrLocked;
    isWrsr && srp_r[1];
  endsequence

  chk_soft_mode_write: assert property (wrsrTaken |=> cmp_r == $past(cmdWord[FSP_B_CMP]))
    else $error("status write refused in software mode");
  chk_hard_wp_low: assert property (
    isWrsr && (srp_r == FSP_SRP_HARD) && !wpSync_r && !qe_r |=> $stable(bp_r) && $stable(srp_r))
    else $error("status write taken while write-protect pin low");
  chk_lockdown_mode: assert property (wrsrLocked |=> $stable({bp_r, tb_r, sec_r, cmp_r, srp_r}))
    else $error("status write taken in lock-down mode");
  chk_lock_sticky: assert property (|lb_r |=> ((lb_r & $past(lb_r)) == $past(lb_r)))
    else $error("security lock bit cleared");
  chk_qpi_needs_qe: assert property (!qe_r && !qpi_r |=> !qpi_r)
    else $error("four-wire mode entered without quad enable");
  chk_qpi_keeps_qe: assert property (qpi_r |-> qe_r)
    else $error("quad enable cleared in four-wire mode");
  chk_suspend_flag: assert property (isSusp |=> sus_r)
    else $error("suspend flag not set");
  chk_resume_clears: assert property (isResume |=> !sus_r)
    else $error("suspend flag kept after resume");
  chk_deny_protected: assert property (opReq && isProtected |=> opDeny && !opGrant)
    else $error("protected operation granted");
  chk_pins_data_mode: assert property (qe_r |=> !pauseActive && !resetRequest)
    else $error("pause or reset active with quad enable");
  chk_wel_clears: assert property (acceptWrite |=> !wel_r ##1 (fourWireMode == $past(qpi_r)))
    else $error("write-enable latch kept after status write");
  chk_wel_op_done: assert property (opDone && !isWren |=> !wel_r)
    else $error("write-enable latch kept after operation done");
  chk_drive_quarter: assert property (drv_r == 2'h3 |=> drivePercent == FSP_DRV_25)
    else $error("drive strength not quarter");
  chk_pin_reset: assert property (!qe_r && hrst_r && !pinSync_r |=> resetRequest && lockInit)
    else $error("pin reset not passed to lock array");
endmodule : fsp_status_protect
`default_nettype wire

// file: fsp_status_protect_tail.sv
// Holds no logic of the status block
`default_nettype none
`default_nettype wire
